//--- rtl/dsip_pkg.sv
// Constants shared by the DAC serial input port
package dsip_pkg;

	localparam int WORD_BITS = 8;
	localparam int CNT_BITS = 4;
	localparam logic [WORD_BITS-1:0] SHIFT_RESET = 8'h00;
	localparam logic [WORD_BITS-1:0] DAC_RESET = 8'h00;
	localparam logic [CNT_BITS-1:0] CNT_RESET = 4'h0;
	localparam logic [CNT_BITS-1:0] CNT_FULL = 4'h8;

	// Frame states, Gray coded along idle -> shifting -> full
	typedef enum logic [1:0] {
		DSIP_IDLE = 2'b00,
		DSIP_SHIFT = 2'b01,
		DSIP_FULL = 2'b11,
		DSIP_OVER = 2'b10
	} dsip_state_t;

endpackage

//--- rtl/dsip_sync.sv
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ns
`default_nettype none
module dsip_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic din,
	output logic dout
);

	logic meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			dout <= RESET_VAL;
		end else if (ce) begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end

endmodule // dsip_sync
`default_nettype wire

//--- rtl/dsip_edge.sv
// Edge detector on a synchronised level
`timescale 1ns/1ns
`default_nettype none
module dsip_edge #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic level,
	output logic rise,
	output logic fall
);

	logic last_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			last_reg <= RESET_VAL;
		end else if (ce) begin
			last_reg <= level;
		end
	end

	assign rise = level & ~last_reg;
	assign fall = ~level & last_reg;

endmodule // dsip_edge
`default_nettype wire

//--- rtl/dsip_port.sv
// Write-only serial input port with DAC register
`timescale 1ns/1ns
`default_nettype none
module dsip_port #(
	parameter int WORD_BITS = dsip_pkg::WORD_BITS
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic FRAME_SYNC_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_DATA_IN,
	input wire logic LOAD_DAC_STROBE_N,
	output logic [WORD_BITS-1:0] DAC_CODE,
	output logic DAC_UPDATE,
	output logic IF_POWERED,
	output logic WORD_READY
);

	// ------------------------------------------------------------
	// Pin synchronisers and edge finders
	// ------------------------------------------------------------
	logic sync_n_s;
	logic sclk_s;
	logic sdata_s;
	logic load_n_s;
	logic frame_rise;
	logic frame_fall;
	logic sclk_fall;
	logic frame_low;

	dsip_sync #(.RESET_VAL(1'b1)) u_sync_fs (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .din(FRAME_SYNC_N), .dout(sync_n_s)
	);
	dsip_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .din(SERIAL_CLK), .dout(sclk_s)
	);
	dsip_sync #(.RESET_VAL(1'b0)) u_sync_sd (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .din(SERIAL_DATA_IN), .dout(sdata_s)
	);
	dsip_sync #(.RESET_VAL(1'b1)) u_sync_ld (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .din(LOAD_DAC_STROBE_N), .dout(load_n_s)
	);

	dsip_edge #(.RESET_VAL(1'b1)) u_edge_fs (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .level(sync_n_s),
		.rise(frame_rise), .fall(frame_fall)
	);
	// Serial clock edges only count while the buffers are powered
	dsip_edge #(.RESET_VAL(1'b0)) u_edge_sclk (
		.clk(CORE_CLK), .rst(SYS_RST), .ce(CLK_EN), .level(sclk_s & IF_POWERED),
		.rise(), .fall(sclk_fall)
	);

	assign frame_low = ~sync_n_s;

	// ------------------------------------------------------------
	// Frame state
	// ------------------------------------------------------------
	dsip_pkg::dsip_state_t state_reg;
	dsip_pkg::dsip_state_t state_next;
	logic [dsip_pkg::CNT_BITS-1:0] cnt_reg;
	logic [WORD_BITS-1:0] shift_reg;
	logic take_bit;

	// A bit is only taken inside an open frame and before the word fills
	assign take_bit = sclk_fall & frame_low & (state_reg == dsip_pkg::DSIP_SHIFT);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dsip_pkg::DSIP_IDLE: begin
				if (frame_fall) begin
					state_next = dsip_pkg::DSIP_SHIFT;
				end
			end
			dsip_pkg::DSIP_SHIFT: begin
				if (frame_rise) begin
					state_next = dsip_pkg::DSIP_IDLE;
				end else if (take_bit && cnt_reg == dsip_pkg::CNT_FULL - 4'h1) begin
					state_next = dsip_pkg::DSIP_FULL;
				end
			end
			dsip_pkg::DSIP_FULL: begin
				// Extra clocks after the eighth bit are ignored
				if (frame_rise) begin
					state_next = dsip_pkg::DSIP_IDLE;
				end
			end
			default: begin
				state_next = dsip_pkg::DSIP_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_reg <= dsip_pkg::DSIP_IDLE;
		end else if (CLK_EN) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Input shift register and bit count
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			cnt_reg <= dsip_pkg::CNT_RESET;
		end else if (CLK_EN) begin
			if (frame_fall) begin
				cnt_reg <= dsip_pkg::CNT_RESET;
			end else if (take_bit) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			shift_reg <= WORD_BITS'(dsip_pkg::SHIFT_RESET);
		end else if (CLK_EN && take_bit) begin
			shift_reg <= {shift_reg[WORD_BITS-2:0], sdata_s};
		end
	end

	// ------------------------------------------------------------
	// Word-complete flag, interface power and DAC register
	// ------------------------------------------------------------
	// The flag sets at frame close and holds until the next frame opens, so a late load strobe still transfers
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			WORD_READY <= 1'b0;
		end else if (CLK_EN) begin
			if (frame_fall) begin
				WORD_READY <= 1'b0;
			end else if (frame_rise && state_reg == dsip_pkg::DSIP_FULL) begin
				WORD_READY <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			IF_POWERED <= 1'b0;
		end else if (CLK_EN) begin
			if (frame_rise) begin
				IF_POWERED <= 1'b0;
			end else if (frame_fall) begin
				IF_POWERED <= 1'b1;
			end
		end
	end

	// Load takes the word once it is complete; a held-low strobe makes
	// this fire one cycle after the closing frame edge, once WORD_READY has set there.
	logic load_now;
	assign load_now = ~load_n_s & WORD_READY & ~frame_fall;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			DAC_CODE <= WORD_BITS'(dsip_pkg::DAC_RESET);
			DAC_UPDATE <= 1'b0;
		end else if (CLK_EN) begin
			// Level while loading, so a held strobe reads as one long update
			DAC_UPDATE <= load_now;
			if (load_now) begin
				DAC_CODE <= shift_reg;
			end
		end
	end

endmodule // dsip_port
`default_nettype wire

//--- verification/dsip_port_sva.sv
// Port assertions for the DAC serial input port
`timescale 1ns/1ns
`default_nettype none
module dsip_port_sva #(
	parameter int WORD_BITS = 8
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic FRAME_SYNC_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_DATA_IN,
	input wire logic LOAD_DAC_STROBE_N,
	input wire logic [WORD_BITS-1:0] DAC_CODE,
	input wire logic DAC_UPDATE,
	input wire logic IF_POWERED,
	input wire logic WORD_READY
);
	default clocking cb @(posedge CORE_CLK); endclocking
	// A frozen clock enable legitimately stops every response
	default disable iff (SYS_RST || !CLK_EN);
	sequence s_open; $rose(IF_POWERED); endsequence
	sequence s_close; $fell(IF_POWERED); endsequence
	chk_reset_clear: assert property ($past(SYS_RST) |-> DAC_CODE == 8'h00 && !WORD_READY)
		else $error("state not clear after reset");
	chk_code_load: assert property (!$stable(DAC_CODE) |-> DAC_UPDATE)
		else $error("code changed without a load");
	chk_load_word: assert property ($rose(DAC_UPDATE) |-> $past(WORD_READY))
		else $error("load without a complete word");
	chk_open_noload: assert property ($rose(DAC_UPDATE) |-> !IF_POWERED)
		else $error("load while a frame is open");
	chk_ready_close: assert property ($rose(WORD_READY) |-> s_close)
		else $error("word ready outside frame close");
	chk_ready_clear: assert property (s_open |=> !WORD_READY)
		else $error("word ready kept over a new frame");
	chk_power_up: assert property ($fell(FRAME_SYNC_N) |-> ##[2:5] IF_POWERED)
		else $error("interface not powered after open");
	chk_power_down: assert property ($rose(FRAME_SYNC_N) |-> ##[2:5] !IF_POWERED)
		else $error("interface still powered after close");
	chk_idle_ignore: assert property (!IF_POWERED ##1 !IF_POWERED |-> $stable(WORD_READY))
		else $error("word changed while idle");
	chk_ready_idle: assert property (IF_POWERED |-> !WORD_READY)
		else $error("word ready while a frame is open");
	chk_update_ready: assert property (DAC_UPDATE |-> $past(WORD_READY))
		else $error("update without a complete word");
	chk_code_hold: assert property (!$past(WORD_READY) |-> $stable(DAC_CODE))
		else $error("code changed before a complete word");
endmodule // dsip_port_sva
bind dsip_port dsip_port_sva #(.WORD_BITS(WORD_BITS)) dsip_port_sva_inst (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .FRAME_SYNC_N(FRAME_SYNC_N),
	.SERIAL_CLK(SERIAL_CLK), .SERIAL_DATA_IN(SERIAL_DATA_IN),
	.LOAD_DAC_STROBE_N(LOAD_DAC_STROBE_N), .DAC_CODE(DAC_CODE), .DAC_UPDATE(DAC_UPDATE),
	.IF_POWERED(IF_POWERED), .WORD_READY(WORD_READY));
`default_nettype wire

//--- verification/dsip_host.sv
// Serial master model driving the link pins
`timescale 1ns/1ns
`default_nettype none
module dsip_host (
	output logic fs_n,
	output logic sclk,
	output logic sdi
);
	initial begin
		fs_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end
	// Sends nb bits from w[15] down; open low keeps frame sync high
	task automatic send(input logic [15:0] w, input int nb, input logic open);
		fs_n = ~open;
		#160;
		for (int i = 15; i > 15 - nb; i--) begin
			sdi = w[i];
			#160 sclk = 1'b0;
			#160 sclk = 1'b1;
		end
		fs_n = 1'b1;
		// Data line not held after the frame: no pull on it
		sdi = ~sdi;
		#200;
	endtask
endmodule // dsip_host
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the DAC serial input port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ld_n = 1'b1;
	logic ce = 1'b1;
	logic fs_n, sclk, sdi, upd, pw, rdy;
	logic [7:0] code;
	int num_errors = 0;
	int checks = 0;
	always #20 clk = ~clk;
	dsip_host dsip_host_inst (.fs_n(fs_n), .sclk(sclk), .sdi(sdi));
	dsip_port dsip_port_inst (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce),
		.FRAME_SYNC_N(fs_n), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(sdi),
		.LOAD_DAC_STROBE_N(ld_n), .DAC_CODE(code), .DAC_UPDATE(upd),
		.IF_POWERED(pw), .WORD_READY(rdy));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_pw(input logic v);
		int n;
		for (n = 0; n < 20 && pw !== v; n++) tick(1);
		if (pw !== v) begin
			num_errors++;
			wrap_up();
		end
	endtask
	task automatic load(input logic [7:0] e, input logic u);
		ld_n = 1'b0;
		tick(4);
		`CHK("code", e, code)
		`CHK("update", u, upd)
		ld_n = 1'b1;
		tick(1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_held;
		ld_n = 1'b0;
		fork
			dsip_host_inst.send(16'ha500, 8, 1'b1);
			begin wait_pw(1'b1); `CHK("powered", 1'b1, pw) end
		join
		tick(6);
		`CHK("powered", 1'b0, pw)
		`CHK("code", 8'ha5, code)
		`CHK("update", 1'b1, upd)
		$display("test held done");
	endtask
	task automatic t_strobe;
		ld_n = 1'b1;
		dsip_host_inst.send(16'h3c00, 8, 1'b1);
		tick(6);
		`CHK("ready", 1'b1, rdy)
		`CHK("code", 8'ha5, code)
		`CHK("update", 1'b0, upd)
		load(8'h3c, 1'b1);
		$display("test strobe done");
	endtask
	task automatic t_refuse;
		dsip_host_inst.send(16'hff00, 5, 1'b1);
		tick(6);
		`CHK("ready", 1'b0, rdy)
		load(8'h3c, 1'b0);
		dsip_host_inst.send(16'h8100, 8, 1'b0);
		tick(6);
		`CHK("powered", 1'b0, pw)
		`CHK("ready", 1'b0, rdy)
		load(8'h3c, 1'b0);
		dsip_host_inst.send(16'h6900, 8, 1'b1);
		tick(6);
		load(8'h69, 1'b1);
		$display("test refuse done");
	endtask
	// A frame sent with the clock enable low must leave no trace
	task automatic t_freeze;
		ce = 1'b0;
		dsip_host_inst.send(16'hc300, 8, 1'b1);
		tick(6);
		`CHK("powered", 1'b0, pw)
		`CHK("ready", 1'b1, rdy)
		ce = 1'b1;
		tick(3);
		`CHK("ready", 1'b1, rdy)
		`CHK("code", 8'h69, code)
		`CHK("update", 1'b0, upd)
		$display("test freeze done");
	endtask
	initial begin
		tick(2);
		rst = 1'b0;
		tick(3);
		`CHK("code", 8'h00, code)
		`CHK("ready", 1'b0, rdy)
		t_held();
		t_strobe();
		t_refuse();
		t_freeze();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
